// ===== rtl/flash_self_programming_control.sv
// Purpose: Mode control, unlock chain and HALT-launched command timing for self programming.
// Assumes: The CPU presents one store per cycle on wr_en/wr_addr/wr_data and reports HALT.
// Notes: Flash array operations are timed here; the array itself sits outside this block.
// Operation
// - Block verify finishes within 6.8 ms of its launching HALT.
// - Byte verify takes 27 us per byte from launching HALT.
// - Block erase of the preset block finishes in 8.5 ms.
// - Erased bytes read FFH.
// - Blank check completes within 480 us.
// - Byte write at preset address completes within 150 us.
// - CPU stays stalled while a command runs.
// - Interrupts are held until self-programming mode ends.
// - No RAM access while a command executes.
// - First HALT after mode entry releases within 10 us plus 2 clocks.
// - Pins in self-programming mode hold their HALT standby state.
// - Only the protect byte blocks erase or write, not security.
// - Protect byte image is loaded into mode bits after reset.
// - Mode register bits 2 to 6 are read-only.
// - Mode bit clears on reset; when set, HALT launches the command.
// - Mode register writes only succeed through the unlock sequence.
// - Unlock is key, value, inverse, value; fourth write takes effect.
// - Sequence violation sets the error flag and leaves mode unchanged.
`timescale 1ns/100ps
module flash_self_programming_control #(
  parameter int VERIFY_BLOCK_CYCLES = flash_self_prog_pkg::VERIFY_BLOCK_CYC,
  parameter int VERIFY_BYTE_CYCLES = flash_self_prog_pkg::VERIFY_BYTE_CYC,
  parameter int ERASE_CYCLES = flash_self_prog_pkg::ERASE_CYC,
  parameter int BLANK_CYCLES = flash_self_prog_pkg::BLANK_CYC,
  parameter int WRITE_CYCLES = flash_self_prog_pkg::WRITE_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [15:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic halt_exec,
  input wire logic [4:0] protect_byte,
  input wire logic protect_hit,
  input wire logic [7:0] verify_bytes,
  input wire logic irq_in,
  output logic [7:0] flash_mode_ctrl,
  output logic protect_seq_error,
  output logic cpu_stall,
  output logic ram_block,
  output logic irq_hold,
  output logic pins_standby,
  output logic flash_start,
  output logic flash_blocked,
  output logic [7:0] erase_fill
);
  if (ERASE_CYCLES < 1 || WRITE_CYCLES < 1 || BLANK_CYCLES < 1 ||
      VERIFY_BLOCK_CYCLES < 1 || VERIFY_BYTE_CYCLES < 1) begin : g_bad_duration
    $error("Command durations must be at least one cycle.");
  end

  typedef enum logic [2:0] {IDLE, KEYED, VAL1, VAL2} seq_t;
  typedef enum logic [1:0] {RUN, ENTRY, BUSY} exec_t;

  seq_t seq_reg, seq_next;
  exec_t exec_reg, exec_next;
  logic mode_reg, mode_next;
  logic [4:0] image_reg;
  logic img_loaded_reg;
  logic entry_pending_reg, entry_pending_next;
  logic [2:0] cmd_reg;
  logic [7:0] val_reg;
  logic err_reg, err_next;
  logic [31:0] cnt_reg, cnt_next;
  logic irq_pend_reg;
  logic [31:0] entry_age_reg;
  logic [31:0] busy_age_reg;

  // A wrong key value counts as a stray store, so a runaway write cannot arm the chain.
  wire wr_prot = wr_en && wr_addr == flash_self_prog_pkg::PROTECT_CMD_ADDR;
  wire wr_key = wr_prot && wr_data == flash_self_prog_pkg::UNLOCK_KEY;
  wire wr_mode = wr_en && wr_addr == flash_self_prog_pkg::FLASH_MODE_CTRL_ADDR;
  wire wr_stat = wr_en && wr_addr == flash_self_prog_pkg::FLASH_STATUS_ADDR;
  wire wr_cmd = wr_en && wr_addr == flash_self_prog_pkg::PROG_CMD_ADDR;
  wire seq_ok = wr_mode && seq_reg == VAL2 && wr_data == val_reg;
  wire inv_ok = wr_mode && wr_data == ~val_reg;
  wire is_erase_or_write = cmd_reg == flash_self_prog_pkg::CMD_ERASE ||
                           cmd_reg == flash_self_prog_pkg::CMD_WRITE;
  wire blocked = protect_hit && is_erase_or_write;
  wire [31:0] byte_verify_cyc = 32'(VERIFY_BYTE_CYCLES) * {24'h000000, verify_bytes};
  logic [31:0] cmd_cycles;
  logic seq_fault;

  always_comb begin
    case (cmd_reg)
      flash_self_prog_pkg::CMD_VERIFY_BLOCK: cmd_cycles = 32'(VERIFY_BLOCK_CYCLES);
      flash_self_prog_pkg::CMD_VERIFY_BYTE: cmd_cycles = byte_verify_cyc;
      flash_self_prog_pkg::CMD_ERASE: cmd_cycles = 32'(ERASE_CYCLES);
      flash_self_prog_pkg::CMD_BLANK: cmd_cycles = 32'(BLANK_CYCLES);
      flash_self_prog_pkg::CMD_WRITE: cmd_cycles = 32'(WRITE_CYCLES);
      default: cmd_cycles = 32'h00000001;
    endcase
  end

  // Any store that breaks the chain counts as a violation; the mode bit is left alone.
  always_comb begin
    seq_next = seq_reg;
    seq_fault = 1'b0;
    if (wr_en) begin
      case (seq_reg)
        IDLE: begin
          if (wr_mode || (wr_prot && !wr_key)) seq_fault = 1'b1;
          seq_next = wr_key ? KEYED : IDLE;
        end
        KEYED: begin
          seq_fault = !wr_mode;
          seq_next = wr_mode ? VAL1 : IDLE;
        end
        VAL1: begin
          seq_fault = !inv_ok;
          seq_next = inv_ok ? VAL2 : IDLE;
        end
        VAL2: begin
          seq_fault = !seq_ok;
          seq_next = IDLE;
        end
        default: seq_next = IDLE;
      endcase
    end
  end

  always_comb begin
    mode_next = seq_ok ? wr_data[flash_self_prog_pkg::MODE_SEL_BIT] : mode_reg;
    entry_pending_next = entry_pending_reg;
    if (seq_ok && wr_data[flash_self_prog_pkg::MODE_SEL_BIT] && !mode_reg) begin
      entry_pending_next = 1'b1;
    end
    // A fault in the same cycle as a software clear still sets the flag.
    err_next = err_reg;
    if (wr_stat && !wr_data[flash_self_prog_pkg::SEQ_ERR_BIT]) err_next = 1'b0;
    if (seq_fault) err_next = 1'b1;
    exec_next = exec_reg;
    cnt_next = cnt_reg;
    case (exec_reg)
      RUN: begin
        if (halt_exec && mode_reg && entry_pending_reg) begin
          exec_next = ENTRY;
          cnt_next = 32'(flash_self_prog_pkg::ENTRY_CYC);
          entry_pending_next = 1'b0;
        end else if (halt_exec && mode_reg) begin
          exec_next = BUSY;
          cnt_next = blocked ? 32'h00000001 : cmd_cycles;
        end
      end
      ENTRY, BUSY: begin
        cnt_next = cnt_reg - 32'h00000001;
        if (cnt_reg <= 32'h00000001) exec_next = RUN;
      end
      default: exec_next = RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      seq_reg <= IDLE;
      exec_reg <= RUN;
      mode_reg <= 1'b0;
      entry_pending_reg <= 1'b0;
      err_reg <= 1'b0;
      cnt_reg <= 32'h00000000;
    end else begin
      seq_reg <= seq_next;
      exec_reg <= exec_next;
      mode_reg <= mode_next;
      entry_pending_reg <= entry_pending_next;
      err_reg <= err_next;
      cnt_reg <= cnt_next;
    end
  end

  // The protect byte pins are only caught after release, never under reset.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      img_loaded_reg <= 1'b0;
      image_reg <= 5'h00;
      cmd_reg <= 3'h0;
      val_reg <= 8'h00;
      irq_pend_reg <= 1'b0;
    end else begin
      if (!img_loaded_reg) begin
        image_reg <= protect_byte;
        img_loaded_reg <= 1'b1;
      end
      if (wr_cmd && exec_reg == RUN) cmd_reg <= wr_data[2:0];
      if (wr_mode && seq_reg == KEYED) val_reg <= wr_data;
      // Requests seen in self-programming mode are remembered until the mode ends.
      irq_pend_reg <= mode_next ? (irq_pend_reg | irq_in) : 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flash_mode_ctrl <= 8'h00;
      protect_seq_error <= 1'b0;
      cpu_stall <= 1'b0;
      ram_block <= 1'b0;
      irq_hold <= 1'b0;
      pins_standby <= 1'b0;
      flash_start <= 1'b0;
      flash_blocked <= 1'b0;
      erase_fill <= flash_self_prog_pkg::BLANK_VALUE;
    end else begin
      flash_mode_ctrl <= {1'b0, image_reg, 1'b0, mode_next};
      protect_seq_error <= err_next;
      cpu_stall <= exec_next != RUN;
      ram_block <= exec_next == BUSY;
      irq_hold <= mode_next;
      pins_standby <= mode_next || exec_next != RUN;
      flash_start <= exec_reg == RUN && exec_next == BUSY && !blocked;
      flash_blocked <= exec_reg == RUN && exec_next == BUSY && blocked;
      erase_fill <= flash_self_prog_pkg::BLANK_VALUE;
    end
  end

  // Cycle counters stand in for long delay ranges, which the tools unroll slowly.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      entry_age_reg <= 32'h00000000;
      busy_age_reg <= 32'h00000000;
    end else begin
      entry_age_reg <= (exec_reg == ENTRY) ? entry_age_reg + 32'h00000001 : 32'h00000000;
      busy_age_reg <= (exec_reg == BUSY) ? busy_age_reg + 32'h00000001 : 32'h00000000;
    end
  end

  // The unlock chain spans four stores, so it is checked as two named halves.
  sequence s_key_then_value;
    (seq_reg == IDLE && wr_key) ##1 wr_mode;
  endsequence
  sequence s_inverse_then_value;
    inv_ok ##1 seq_ok;
  endsequence

  // A blocked erase or write ends after one cycle, well inside every bound below.
  a_entry_release: assert property (@(posedge clk) disable iff (!reset_n)
    exec_reg == ENTRY |-> entry_age_reg < 32'(flash_self_prog_pkg::ENTRY_CYC))
    else $error("Entry HALT not released in time.");
  a_bad_seq_flag: assert property (@(posedge clk) disable iff (!reset_n)
    seq_fault |=> protect_seq_error)
    else $error("Sequence fault did not raise the error flag.");
  a_mode_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !seq_ok |=> mode_reg == $past(mode_reg))
    else $error("Mode changed outside the unlock sequence.");
  a_stall_busy: assert property (@(posedge clk) disable iff (!reset_n)
    exec_reg != RUN |-> cpu_stall)
    else $error("CPU not stalled during command.");
  a_ram_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    exec_reg == BUSY |-> ram_block)
    else $error("RAM not blocked during command.");
  a_ro_bits: assert property (@(posedge clk) disable iff (!reset_n)
    flash_mode_ctrl[7] == 1'b0 && flash_mode_ctrl[1] == 1'b0)
    else $error("Reserved mode bits not zero.");
  a_irq_held: assert property (@(posedge clk) disable iff (!reset_n)
    mode_reg |-> irq_hold)
    else $error("Interrupts not held in self-programming mode.");
  a_blank_fill: assert property (@(posedge clk) disable iff (!reset_n)
    erase_fill == flash_self_prog_pkg::BLANK_VALUE)
    else $error("Erase fill value wrong.");
  a_cmd_release: assert property (@(posedge clk) disable iff (!reset_n)
    exec_reg == BUSY && cnt_reg == 32'h00000001 |=> exec_reg == RUN)
    else $error("HALT not released at command end.");
  a_verify_block_len: assert property (@(posedge clk) disable iff (!reset_n)
    exec_reg == BUSY && cmd_reg == flash_self_prog_pkg::CMD_VERIFY_BLOCK |->
    busy_age_reg < 32'(VERIFY_BLOCK_CYCLES))
    else $error("Block verify ran too long.");
  a_verify_byte_len: assert property (@(posedge clk) disable iff (!reset_n)
    exec_reg == BUSY && cmd_reg == flash_self_prog_pkg::CMD_VERIFY_BYTE |->
    busy_age_reg <= byte_verify_cyc)
    else $error("Byte verify ran too long.");
  a_erase_len: assert property (@(posedge clk) disable iff (!reset_n)
    exec_reg == BUSY && cmd_reg == flash_self_prog_pkg::CMD_ERASE |->
    busy_age_reg < 32'(ERASE_CYCLES))
    else $error("Block erase ran too long.");
  a_blank_len: assert property (@(posedge clk) disable iff (!reset_n)
    exec_reg == BUSY && cmd_reg == flash_self_prog_pkg::CMD_BLANK |->
    busy_age_reg < 32'(BLANK_CYCLES))
    else $error("Blank check ran too long.");
  a_write_len: assert property (@(posedge clk) disable iff (!reset_n)
    exec_reg == BUSY && cmd_reg == flash_self_prog_pkg::CMD_WRITE |->
    busy_age_reg < 32'(WRITE_CYCLES))
    else $error("Byte write ran too long.");
  a_start_mode: assert property (@(posedge clk) disable iff (!reset_n)
    flash_start |-> $past(mode_reg))
    else $error("Command started outside self-programming mode.");
  a_block_flag: assert property (@(posedge clk) disable iff (!reset_n)
    flash_blocked |-> $past(protect_hit))
    else $error("Command blocked without a protected address.");
  a_image_load: assert property (@(posedge clk) disable iff (!reset_n)
    img_loaded_reg |=> flash_mode_ctrl[6:2] == image_reg)
    else $error("Protect byte image not shown in mode register.");
  a_unlock_apply: assert property (@(posedge clk) disable iff (!reset_n)
    s_key_then_value ##1 s_inverse_then_value |=> flash_mode_ctrl[0] == $past(wr_data[0]))
    else $error("Unlock chain did not set the mode bit.");
  a_irq_pend: assert property (@(posedge clk) disable iff (!reset_n)
    irq_pend_reg |-> irq_hold)
    else $error("Pending interrupt not held.");
endmodule : flash_self_programming_control

// ===== rtl/flash_self_prog_pkg.sv
// Purpose: Constants shared by the flash self-programming control block.
// Assumes: 125 MHz CPU clock, byte-wide peripheral store bus.
// Notes: Times are kept in their own units and converted to cycles here.
package flash_self_prog_pkg;
  localparam int CLK_MHZ = 125;
  localparam logic [15:0] FLASH_STATUS_ADDR = 16'hffa1;
  localparam logic [15:0] FLASH_MODE_CTRL_ADDR = 16'hffa2;
  localparam logic [15:0] PROG_CMD_ADDR = 16'hffa3;
  localparam logic [15:0] PROTECT_CMD_ADDR = 16'hffa0;
  localparam logic [15:0] PROTECT_BYTE_ADDR = 16'h0081;
  localparam logic [7:0] UNLOCK_KEY = 8'ha5;
  localparam logic [7:0] BLANK_VALUE = 8'hff;
  localparam logic [7:0] CMD_CLEAR = 8'h00;
  localparam logic [2:0] CMD_VERIFY_BLOCK = 3'h1;
  localparam logic [2:0] CMD_VERIFY_BYTE = 3'h2;
  localparam logic [2:0] CMD_ERASE = 3'h3;
  localparam logic [2:0] CMD_BLANK = 3'h4;
  localparam logic [2:0] CMD_WRITE = 3'h5;
  localparam int MODE_SEL_BIT = 0;
  localparam int SEQ_ERR_BIT = 0;
  localparam int VERIFY_BLOCK_US = 6800;
  localparam int VERIFY_BYTE_US = 27;
  localparam int ERASE_US = 8500;
  localparam int BLANK_US = 480;
  localparam int WRITE_US = 150;
  localparam int ENTRY_US = 10;
  localparam int ENTRY_EXTRA_CLK = 2;
  localparam int VERIFY_BLOCK_CYC = VERIFY_BLOCK_US * CLK_MHZ;
  localparam int VERIFY_BYTE_CYC = VERIFY_BYTE_US * CLK_MHZ;
  localparam int ERASE_CYC = ERASE_US * CLK_MHZ;
  localparam int BLANK_CYC = BLANK_US * CLK_MHZ;
  localparam int WRITE_CYC = WRITE_US * CLK_MHZ;
  localparam int ENTRY_CYC = ENTRY_US * CLK_MHZ + ENTRY_EXTRA_CLK;
  localparam logic [7:0] STATUS_RESET = 8'h00;
endpackage : flash_self_prog_pkg

// ===== dv/tb.sv
// Purpose: Self-checking bench for the flash self-programming control block.
// Assumes: Shortened command durations; stores and HALT pulses driven at the falling edge.
// Notes: A blocked erase or write is expected to stall for one cycle only.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((e) !== (g)) begin num_errors++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb;
  localparam int VB = 20;
  localparam int VY = 3;
  localparam int ER = 30;
  localparam int BL = 10;
  localparam int WR = 7;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic wr_en = 1'b0;
  logic halt_exec = 1'b0;
  logic protect_hit = 1'b0;
  logic irq_in = 1'b0;
  logic [15:0] wr_addr = 16'h0000;
  logic [7:0] wr_data = 8'h00;
  logic [7:0] verify_bytes = 8'h01;
  logic [4:0] protect_byte = 5'h00;
  logic [7:0] flash_mode_ctrl;
  logic [7:0] erase_fill;
  logic protect_seq_error, cpu_stall, ram_block, irq_hold, pins_standby;
  logic flash_start, flash_blocked, s_start, s_blk, s_ram, s_pins, blk;
  logic [4:0] pb;
  logic [2:0] c;
  int num_errors = 0;
  int comparisons = 0;
  int n;
  always #4 clk = ~clk;
  flash_self_programming_control #(.VERIFY_BLOCK_CYCLES(VB), .VERIFY_BYTE_CYCLES(VY),
    .ERASE_CYCLES(ER), .BLANK_CYCLES(BL), .WRITE_CYCLES(WR)) u_dut (
    .clk(clk), .reset_n(reset_n), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .halt_exec(halt_exec), .protect_byte(protect_byte), .protect_hit(protect_hit),
    .verify_bytes(verify_bytes), .irq_in(irq_in), .flash_mode_ctrl(flash_mode_ctrl),
    .protect_seq_error(protect_seq_error), .cpu_stall(cpu_stall), .ram_block(ram_block),
    .irq_hold(irq_hold), .pins_standby(pins_standby), .flash_start(flash_start),
    .flash_blocked(flash_blocked), .erase_fill(erase_fill));
  function automatic int dur(input logic [2:0] cmd, input logic [7:0] nb);
    case (cmd)
      flash_self_prog_pkg::CMD_VERIFY_BLOCK: return VB;
      flash_self_prog_pkg::CMD_VERIFY_BYTE: return VY * int'(nb);
      flash_self_prog_pkg::CMD_ERASE: return ER;
      flash_self_prog_pkg::CMD_BLANK: return BL;
      flash_self_prog_pkg::CMD_WRITE: return WR;
      default: return 0;
    endcase
  endfunction : dur
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  // A store leaves the strobe up so back-to-back stores stay consecutive.
  task automatic store(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
  endtask : store
  task automatic idle;
    @(negedge clk);
    wr_en = 1'b0;
    irq_in = 1'($urandom);
  endtask : idle
  task automatic unlock(input logic [7:0] v);
    store(flash_self_prog_pkg::PROTECT_CMD_ADDR, flash_self_prog_pkg::UNLOCK_KEY);
    store(flash_self_prog_pkg::FLASH_MODE_CTRL_ADDR, v);
    store(flash_self_prog_pkg::FLASH_MODE_CTRL_ADDR, ~v);
    store(flash_self_prog_pkg::FLASH_MODE_CTRL_ADDR, v);
    idle();
  endtask : unlock
  task automatic halt_count(output int cnt, input int limit);
    @(negedge clk);
    halt_exec = 1'b1;
    @(negedge clk);
    halt_exec = 1'b0;
    cnt = 0;
    s_start = flash_start;
    s_blk = flash_blocked;
    s_ram = ram_block;
    s_pins = pins_standby;
    while (cpu_stall === 1'b1 && cnt < limit) begin
      cnt++;
      @(negedge clk);
    end
    if (cnt >= limit) begin
      num_errors++;
      $display("ERROR stall wait expected release seen none");
      end_of_test();
    end
  endtask : halt_count
  initial begin
    void'($urandom(1158));
    protect_byte = 5'($urandom);
    pb = protect_byte;
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("mode_ctrl", {1'b0, pb, 2'b00}, flash_mode_ctrl)
    `CHK("fill", flash_self_prog_pkg::BLANK_VALUE, erase_fill)
    halt_count(n, 10);
    `CHK("normal_halt", 0, n)
    `CHK("normal_start", 1'b0, s_start)
    store(flash_self_prog_pkg::FLASH_MODE_CTRL_ADDR, 8'h01);
    idle();
    `CHK("err_direct", 1'b1, protect_seq_error)
    `CHK("mode_direct", 1'b0, flash_mode_ctrl[0])
    store(flash_self_prog_pkg::FLASH_STATUS_ADDR, 8'h00);
    idle();
    `CHK("err_clear", 1'b0, protect_seq_error)
    store(flash_self_prog_pkg::PROTECT_CMD_ADDR, flash_self_prog_pkg::UNLOCK_KEY);
    store(flash_self_prog_pkg::FLASH_MODE_CTRL_ADDR, 8'h01);
    store(flash_self_prog_pkg::FLASH_MODE_CTRL_ADDR, 8'h01);
    idle();
    `CHK("err_inverse", 1'b1, protect_seq_error)
    `CHK("mode_inverse", 1'b0, flash_mode_ctrl[0])
    store(flash_self_prog_pkg::FLASH_STATUS_ADDR, 8'h00);
    idle();
    `CHK("err_reclear", 1'b0, protect_seq_error)
    store(flash_self_prog_pkg::PROTECT_CMD_ADDR, 8'h5a);
    store(flash_self_prog_pkg::FLASH_MODE_CTRL_ADDR, 8'h01);
    store(flash_self_prog_pkg::FLASH_MODE_CTRL_ADDR, 8'hfe);
    store(flash_self_prog_pkg::FLASH_MODE_CTRL_ADDR, 8'h01);
    idle();
    `CHK("err_wrong_key", 1'b1, protect_seq_error)
    `CHK("mode_wrong_key", 1'b0, flash_mode_ctrl[0])
    store(flash_self_prog_pkg::FLASH_STATUS_ADDR, 8'h00);
    store(flash_self_prog_pkg::PROG_CMD_ADDR, flash_self_prog_pkg::CMD_CLEAR);
    idle();
    unlock(8'hff);
    `CHK("mode_set", {1'b0, pb, 1'b0, 1'b1}, flash_mode_ctrl)
    `CHK("irq_hold", 1'b1, irq_hold)
    halt_count(n, 2000);
    `CHK("entry_release", 1'b1, n > 0 && n <= flash_self_prog_pkg::ENTRY_CYC)
    repeat (1000) @(negedge clk);
    for (int i = 0; i < 10; i++) begin
      c = (i < 5) ? 3'(i + 1) : (i == 5) ? flash_self_prog_pkg::CMD_ERASE :
          (i == 6) ? flash_self_prog_pkg::CMD_WRITE : (i == 7) ?
          flash_self_prog_pkg::CMD_BLANK : 3'($urandom_range(1, 5));
      verify_bytes = 8'($urandom_range(1, 8));
      protect_hit = (i >= 5 && i <= 7);
      blk = protect_hit && (c == flash_self_prog_pkg::CMD_ERASE ||
            c == flash_self_prog_pkg::CMD_WRITE);
      store(flash_self_prog_pkg::PROG_CMD_ADDR, {5'h00, c});
      idle();
      halt_count(n, 400);
      `CHK("stall_len", blk ? 1 : dur(c, verify_bytes), n)
      `CHK("start", !blk, s_start)
      `CHK("blocked", blk, s_blk)
      if (!blk) `CHK("ram_block", 1'b1, s_ram)
      if (!blk) `CHK("pins", 1'b1, s_pins)
      `CHK("released", 1'b0, cpu_stall)
      `CHK("fill_after", flash_self_prog_pkg::BLANK_VALUE, erase_fill)
    end
    protect_hit = 1'b0;
    for (int r = 0; r < 2; r++) begin
      store(flash_self_prog_pkg::PROG_CMD_ADDR, {5'h00, flash_self_prog_pkg::CMD_ERASE});
      idle();
      halt_count(n, 400);
      `CHK("erase_retry", ER, n)
    end
    store(flash_self_prog_pkg::PROG_CMD_ADDR, flash_self_prog_pkg::CMD_CLEAR);
    idle();
    unlock(8'h00);
    `CHK("mode_exit", 1'b0, flash_mode_ctrl[0])
    `CHK("irq_release", 1'b0, irq_hold)
    end_of_test();
  end
endmodule : tb
